// File: lmsr_refresh.sv
`timescale 1ns/10ps
`include "lmsr_cfg.svh"

// Function
// - Font covers 128 characters, 640 entries
// - Font entries grouped column by column
// - Font bits 6..0 are rows 7..1
// - Font one lights dot, zero dark
// - Dot memory holds 32-character image
// - Counters address each serialised written bit
// - Dot image scanned out column by column
// - Code memory 128 words of 8 bits
// - Scan logic alone decodes and loads
// - Scales up to 128 characters
// - Host access beats scan access
// - Continuously read, decode, display codes
// - Five column bits, column mux selects
// - Modulo-8 row counter steps seven rows
// - Seven display clocks per row cycle
// - Scan counter: character address plus phase
// - All phase bits one means load
// - Other phases drive column, then advance
// - Seven of eight phases display, 17.5%
// - 64 characters: two phase bits, 15%
// - 128 characters need faster scan clock
// - Load phase blanks, drivers all off
// - Row seven serialised first
module lmsr_refresh #(
    parameter int CHARS  = `LMSR_STRING_CHARS,  // Characters in string
    parameter int SCAN_W = `LMSR_SCAN_BITS,     // Scan counter width
    parameter bit CODED  = 1'b1                 // 1: codes + font, 0: dot image
) (
    // Core clock and reset
    input  wire logic                 i_clock,
    input  wire logic                 i_reset,
    // Host write port, host clock domain
    input  wire logic                 i_host_clock,
    input  wire logic                 i_host_wr,
    input  wire lmsr_pkg::lmsr_req_s  i_host_req,
    output logic                      o_host_busy,
    // Display string
    output logic                      o_disp_data,
    output logic                      o_disp_clock,
    output logic                      o_disp_blank,
    // Column drivers, one-hot
    output logic [`LMSR_COLS-1:0]     o_col_on
);

    // ----------------------------------------
    // Derived sizes
    // ----------------------------------------
    localparam int CHAR_W  = $clog2(CHARS);             // Character address bits
    localparam int PHASE_W = SCAN_W - CHAR_W;           // Load/display phase bits
    localparam int DOT_N   = `LMSR_COLS * CHARS * `LMSR_ROWS;
    localparam int DOT_W   = $clog2(DOT_N);             // Dot image address bits
    localparam int FONT_W  = $clog2(`LMSR_FONT_ENTRIES);

    // ----------------------------------------
    // Helper functions
    // ----------------------------------------
    // True when all phase bits are one
    function automatic logic is_load(input logic [SCAN_W-1:0] s);
        is_load = &s[SCAN_W-1:CHAR_W];
    endfunction

    // Bit address in the dot image: column, character, row
    function automatic logic [DOT_W-1:0] dot_addr(input logic [2:0] c,
                                                  input logic [CHAR_W-1:0] ch,
                                                  input logic [2:0] r);
        logic [31:0] a;
        a = (32'(c) * 32'(CHARS) + 32'(ch)) * 32'(`LMSR_ROWS) + 32'(r);
        dot_addr = a[DOT_W-1:0];
    endfunction

    // Font entry index, column-major
    function automatic logic [FONT_W-1:0] font_idx(input logic [2:0] c,
                                                   input logic [6:0] code);
        logic [31:0] a;
        a = 32'(c) * 32'(`LMSR_FONT_CHARS) + 32'(code);
        font_idx = a[FONT_W-1:0];
    endfunction

    // One-hot column driver pattern
    function automatic logic [`LMSR_COLS-1:0] col_hot(input logic [2:0] c);
        col_hot = `LMSR_COLS'(1) << c;
    endfunction

    // ----------------------------------------
    // Host domain: request capture
    // ----------------------------------------
    lmsr_pkg::lmsr_req_s  hreq_q;     // Held request
    logic                 hreq_tgl_q; // Request toggle
    logic                 hack_s1_q;  // Ack synchroniser stage 1
    logic                 hack_s2_q;  // Ack synchroniser stage 2
    logic                 hbusy_q;    // Request outstanding
    logic                 ack_tgl_q;  // Core-domain ack toggle

    wire host_take = i_host_wr & ~hbusy_q;      // Accept only when idle
    wire host_done = hack_s2_q == hreq_tgl_q;   // Core has acknowledged

    // Ack toggle synchroniser
    always_ff @(posedge i_host_clock or posedge i_reset) begin
        if (i_reset) begin
            hack_s1_q <= 1'b0;
            hack_s2_q <= 1'b0;
        end else begin
            hack_s1_q <= ack_tgl_q;
            hack_s2_q <= hack_s1_q;
        end
    end

    // Capture request and raise busy
    always_ff @(posedge i_host_clock or posedge i_reset) begin
        if (i_reset) begin
            hreq_q     <= '0;
            hreq_tgl_q <= 1'b0;
            hbusy_q    <= 1'b0;
        end else if (host_take) begin
            hreq_q     <= i_host_req;
            hreq_tgl_q <= ~hreq_tgl_q;
            hbusy_q    <= 1'b1;
        end else if (hbusy_q && host_done) begin
            hbusy_q    <= 1'b0;
        end
    end

    assign o_host_busy = hbusy_q;

    // ----------------------------------------
    // Core domain: request synchroniser
    // ----------------------------------------
    logic req_s1_q;  // Stage 1, read only by stage 2
    logic req_s2_q;  // Stage 2
    logic req_s3_q;  // Edge reference

    // Request toggle into core clock
    always_ff @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            req_s1_q <= 1'b0;
            req_s2_q <= 1'b0;
            req_s3_q <= 1'b0;
        end else begin
            req_s1_q <= hreq_tgl_q;
            req_s2_q <= req_s1_q;
            req_s3_q <= req_s2_q;
        end
    end

    wire req_new = req_s2_q ^ req_s3_q;  // New held request visible

    // ----------------------------------------
    // Core domain: write sequencer
    // ----------------------------------------
    lmsr_pkg::lmsr_wr_e  wr_q;     // Sequencer state
    lmsr_pkg::lmsr_wr_e  wr_d;
    logic [2:0]          wbit_q;   // Bit being serialised
    logic [2:0]          wbit_d;
    logic                ack_d;

    // Fields of the held request, stable while busy
    wire [1:0]        w_sel  = hreq_q.sel;
    wire [6:0]        w_code = hreq_q.addr[6:0];
    wire [2:0]        w_col  = hreq_q.addr[`LMSR_ADDR_W-1:`LMSR_COL_LSB];
    wire [CHAR_W-1:0] w_char = hreq_q.addr[CHAR_W-1:0];
    wire              w_last = wbit_q == `LMSR_TOP_ROW;
    wire [DOT_W-1:0]  w_dot  = dot_addr(w_col, w_char, wbit_q);

    wire stall = wr_q != lmsr_pkg::LMSR_WR_IDLE;

    // Next state of the sequencer
    always_comb begin
        wr_d   = wr_q;
        wbit_d = wbit_q;
        ack_d  = ack_tgl_q;
        unique case (wr_q)
            lmsr_pkg::LMSR_WR_IDLE: begin
                // Pick word or bit-serial write
                if (req_new) begin
                    wbit_d = `LMSR_RST_ROW;
                    wr_d   = (w_sel == `LMSR_SEL_DOTS) ? lmsr_pkg::LMSR_WR_BITS
                                                       : lmsr_pkg::LMSR_WR_WORD;
                end
            end
            lmsr_pkg::LMSR_WR_WORD: begin
                // Single memory word written
                ack_d = ~ack_tgl_q;
                wr_d  = lmsr_pkg::LMSR_WR_IDLE;
            end
            lmsr_pkg::LMSR_WR_BITS: begin
                wbit_d = wbit_q + 3'h1;
                if (w_last) begin
                    ack_d = ~ack_tgl_q;
                    wr_d  = lmsr_pkg::LMSR_WR_IDLE;
                end
            end
            default: begin
                // Illegal code recovers to idle
                wr_d = lmsr_pkg::LMSR_WR_IDLE;
            end
        endcase
    end

    // Sequencer registers
    always_ff @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            wr_q      <= lmsr_pkg::LMSR_WR_IDLE;
            wbit_q    <= `LMSR_RST_ROW;
            ack_tgl_q <= 1'b0;
        end else begin
            wr_q      <= wr_d;
            wbit_q    <= wbit_d;
            ack_tgl_q <= ack_d;
        end
    end

    // ----------------------------------------
    // Local memories
    // ----------------------------------------
    // code memory
    logic [`LMSR_DATA_W-1:0] code_mem [`LMSR_CODE_DEPTH];
    logic [`LMSR_ROWS-1:0]   font_mem [`LMSR_FONT_ENTRIES];
    // full dot image, one bit per dot
    logic                    dot_mem  [DOT_N];

    wire do_word = wr_q == lmsr_pkg::LMSR_WR_WORD;
    wire do_bits = wr_q == lmsr_pkg::LMSR_WR_BITS;

    // Code and font word writes
    always_ff @(posedge i_clock) begin
        if (do_word && w_sel == `LMSR_SEL_CODE) begin
            code_mem[w_code] <= hreq_q.data;
        end
        // index is column times 128 plus code
        if (do_word && w_sel == `LMSR_SEL_FONT) begin
            font_mem[hreq_q.addr[FONT_W-1:0]] <= hreq_q.data[`LMSR_ROWS-1:0];
        end
    end

    always_ff @(posedge i_clock) begin
        if (do_bits) begin
            dot_mem[w_dot] <= hreq_q.data[wbit_q];
        end
    end

    // ----------------------------------------
    // Scan counters
    // ----------------------------------------
    logic              ph_q;      // Half of a bit slot
    logic [2:0]        row_q;     // Row within character
    logic [SCAN_W-1:0] scan_q;    // Character and phase
    logic [2:0]        col_q;     // Column being shown
    logic              loaded_q;  // A full load has finished

    wire               slot_end = ~stall & ph_q;       // Bit slot closes
    wire               row_wrap = row_q == `LMSR_IDLE_ROW;
    wire               char_end = slot_end & row_wrap; // Character slot done
    wire [SCAN_W-1:0]  scan_nx  = scan_q + SCAN_W'(1);
    // low bits character, high bits phase
    wire [CHAR_W-1:0]  cur_char = scan_q[CHAR_W-1:0];
    wire               in_load  = is_load(scan_q);
    wire               to_load  = char_end & ~in_load & is_load(scan_nx);
    wire               load_end = char_end & in_load & ~is_load(scan_nx);
    // seven bit slots per row cycle
    wire               bit_on   = in_load & ~row_wrap;
    // font bit is row less one
    wire [2:0]         bit_row  = `LMSR_TOP_ROW - row_q;

    always_ff @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            ph_q  <= 1'b0;
            row_q <= `LMSR_RST_ROW;
        end else if (!stall) begin
            ph_q  <= ~ph_q;
            row_q <= ph_q ? row_q + 3'h1 : row_q;
        end
    end

    always_ff @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            scan_q <= '0;
        end else if (char_end) begin
            scan_q <= scan_nx;
        end
    end

    always_ff @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            col_q <= `LMSR_RST_COL;
        end else if (to_load && loaded_q) begin
            col_q <= (col_q == `LMSR_LAST_COL) ? `LMSR_RST_COL : col_q + 3'h1;
        end
    end

    // Display stays dark until first load completes
    always_ff @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            loaded_q <= 1'b0;
        end else if (load_end) begin
            loaded_q <= 1'b1;
        end
    end

    // ----------------------------------------
    // Serial bit source
    // ----------------------------------------
    wire [6:0]             cur_code = code_mem[cur_char][6:0];
    wire [`LMSR_COLS-1:0]  five_col;  // One row bit of each column

    genvar k;
    generate
        for (k = 0; k < `LMSR_COLS; k++) begin : g_col
            assign five_col[k] = font_mem[font_idx(3'(k), cur_code)][bit_row];
        end
    endgenerate

    wire code_bit = five_col[col_q];
    // dot image bit of current column
    wire dot_bit  = dot_mem[dot_addr(col_q, cur_char, bit_row)];
    wire ser_bit  = CODED ? code_bit : dot_bit;

    // ----------------------------------------
    // Display outputs
    // ----------------------------------------
    logic                  data_q;   // Serial data
    logic                  clk_q;    // Gated display clock
    logic                  blank_q;  // Blanking level
    logic [`LMSR_COLS-1:0] col_on_q; // Column drivers

    wire dark = in_load | ~loaded_q;  // No column current

    always_ff @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            data_q <= 1'b0;
        end else if (!stall && !ph_q && bit_on) begin
            data_q <= ser_bit;
        end
    end

    always_ff @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            clk_q <= 1'b0;
        end else begin
            clk_q <= slot_end & bit_on;
        end
    end

    // blank and drivers off in load
    always_ff @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            blank_q  <= 1'b1;
            col_on_q <= `LMSR_RST_COL_ON;
        end else begin
            blank_q  <= dark;
            col_on_q <= dark ? `LMSR_RST_COL_ON : col_hot(col_q);
        end
    end

    // CHARS 64 leaves two phase bits
    // CHARS 128 pairs with SCAN_W 9, faster clock
    assign o_disp_data  = data_q;
    assign o_disp_clock = clk_q;
    assign o_disp_blank = blank_q;
    assign o_col_on     = col_on_q;

endmodule

// File: lmsr_cfg.svh
`ifndef LMSR_CFG_SVH
`define LMSR_CFG_SVH

// ----------------------------------------
// Geometry of characters and font table
// ----------------------------------------
`define LMSR_ROWS          7
`define LMSR_COLS          5
`define LMSR_FONT_CHARS    128
`define LMSR_FONT_ENTRIES  640
`define LMSR_CODE_DEPTH    128
`define LMSR_STRING_CHARS  32
`define LMSR_SCAN_BITS     8
`define LMSR_TOP_ROW       3'h6
`define LMSR_IDLE_ROW      3'h7
`define LMSR_LAST_COL      3'h4

// ----------------------------------------
// Host request field layout
// ----------------------------------------
`define LMSR_ADDR_W        10
`define LMSR_DATA_W        8
`define LMSR_COL_LSB       7
`define LMSR_SEL_CODE      2'h0
`define LMSR_SEL_FONT      2'h1
`define LMSR_SEL_DOTS      2'h2

// ----------------------------------------
// Reset values
// ----------------------------------------
`define LMSR_RST_ROW       3'h0
`define LMSR_RST_COL       3'h0
`define LMSR_RST_COL_ON    5'h00

`endif

// File: lmsr_pkg.sv
`include "lmsr_cfg.svh"

package lmsr_pkg;

    // ----------------------------------------
    // Host write request, held stable while busy
    // ----------------------------------------
    typedef struct packed {
        logic [1:0]                 sel;   // Target memory
        logic [`LMSR_ADDR_W-1:0]    addr;  // Word or char/column address
        logic [`LMSR_DATA_W-1:0]    data;  // Code, font or column byte
    } lmsr_req_s;

    // ----------------------------------------
    // Local write sequencer states
    // ----------------------------------------
    typedef enum logic [2:0] {
        LMSR_WR_IDLE = 3'b001,
        LMSR_WR_WORD = 3'b010,
        LMSR_WR_BITS = 3'b100
    } lmsr_wr_e;

endpackage

// File: lmsr_refresh_monitor.sv
`timescale 1ns/10ps
`include "lmsr_cfg.svh"

// ----------------------------------------
// Display and host port checker
// ----------------------------------------
module lmsr_refresh_monitor #(
    parameter int CHARS  = 32,  // Characters in string
    parameter int SCAN_W = 8    // Scan counter width
) (
    // Clocks and reset
    input wire logic                 i_clock,
    input wire logic                 i_reset,
    input wire logic                 i_host_clock,
    // Host port
    input wire logic                 i_host_wr,
    input wire logic                 o_host_busy,
    // Display string
    input wire logic                 o_disp_data,
    input wire logic                 o_disp_clock,
    input wire logic                 o_disp_blank,
    input wire logic [`LMSR_COLS-1:0] o_col_on
);
    localparam int CHAR_W = $clog2(CHARS);
    localparam int DISP_C = ((1 << (SCAN_W - CHAR_W)) - 1) * CHARS * 16;
    logic [10:0] pulse_q;  // Display clocks in this load
    logic [15:0] disp_q;   // Lit cycles in this display time
    logic [4:0]  last_q;   // Column lit last

    // Counters restart at each phase change
    always_ff @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            pulse_q <= 11'h000;
            disp_q  <= 16'h0000;
            last_q  <= 5'h00;
        end else begin
            pulse_q <= o_disp_blank ? pulse_q + 11'(o_disp_clock) : 11'h000;
            disp_q  <= o_disp_blank ? 16'h0000 : disp_q + 16'h0001;
            last_q  <= o_disp_blank ? last_q : o_col_on;
        end
    end

    blank_cols_a: assert property (@(posedge i_clock) disable iff (i_reset)
        o_disp_blank |-> o_col_on == 5'h00) else $error("column on while blanked");
    col_onehot_a: assert property (@(posedge i_clock) disable iff (i_reset)
        !o_disp_blank |-> $onehot(o_col_on)) else $error("column select not one-hot");
    clock_gated_a: assert property (@(posedge i_clock) disable iff (i_reset)
        o_disp_clock |-> o_disp_blank) else $error("display clock outside load");
    clock_pulse_a: assert property (@(posedge i_clock) disable iff (i_reset)
        o_disp_clock |=> !o_disp_clock) else $error("display clock wider than one cycle");
    data_steady_a: assert property (@(posedge i_clock) disable iff (i_reset)
        o_disp_clock |-> $stable(o_disp_data)) else $error("serial data moved around clock");
    load_count_a: assert property (@(posedge i_clock) disable iff (i_reset)
        $fell(o_disp_blank) |-> pulse_q == 11'(7 * CHARS)) else $error("wrong bit count in load");
    disp_time_a: assert property (@(posedge i_clock) disable iff (i_reset)
        $rose(o_disp_blank) |-> disp_q >= 16'(DISP_C) && disp_q <= 16'(DISP_C + 64))
        else $error("display time off");
    col_advance_a: assert property (@(posedge i_clock) disable iff (i_reset)
        $fell(o_disp_blank) && last_q != 5'h00 |-> o_col_on == {last_q[3:0], last_q[4]})
        else $error("column did not advance");
    busy_take_a: assert property (@(posedge i_host_clock) disable iff (i_reset)
        i_host_wr && !o_host_busy |=> o_host_busy) else $error("write not taken");
    busy_bound_a: assert property (@(posedge i_host_clock) disable iff (i_reset)
        $rose(o_host_busy) |-> ##[1:24] !o_host_busy) else $error("host write never done");
endmodule

// File: lmsr_display_model.sv
`timescale 1ns/10ps

// ----------------------------------------
// Serial display string, shift only
// ----------------------------------------
module lmsr_display_model #(
    parameter int BITS = 224  // Row bits along string
) (
    // Serial input
    input wire logic            i_disp_data,
    input wire logic            i_disp_clock,
    // Shifted row data, first bit at top
    output logic [BITS-1:0]     o_shift
);
    initial o_shift = '0;

    always @(posedge i_disp_clock) begin
        o_shift <= {o_shift[BITS-2:0], i_disp_data};
    end
endmodule

// File: lmsr_refresh_test.sv
`timescale 1ns/10ps
`include "lmsr_cfg.svh"

module lmsr_refresh_test;
    logic                  clock = 1'b0;       // Core clock
    logic                  host_clock = 1'b0;  // Host clock
    logic                  reset = 1'b1;       // Async reset
    logic                  host_wr = 1'b0;     // Write request
    lmsr_pkg::lmsr_req_s   req = '0;           // Request fields
    wire logic             busy, dat, dclk, blank;
    wire logic [4:0]       col;
    wire logic [223:0]     shift;              // Model contents
    logic [7:0]            code_q [32];        // Codes written
    int                    errors = 0;
    int                    n_tests = 0;
    int                    col_k = 0;          // Column of last checked frame

    always #5 clock = ~clock;
    always #62.5 host_clock = ~host_clock;

    lmsr_refresh #(.CHARS(32), .SCAN_W(8), .CODED(1'b1)) u_lmsr_refresh (
        .i_clock(clock), .i_reset(reset), .i_host_clock(host_clock),
        .i_host_wr(host_wr), .i_host_req(req), .o_host_busy(busy),
        .o_disp_data(dat), .o_disp_clock(dclk), .o_disp_blank(blank), .o_col_on(col));
    lmsr_display_model #(.BITS(224)) u_lmsr_display_model (
        .i_disp_data(dat), .i_disp_clock(dclk), .o_shift(shift));

    // Pattern with both levels in rows
    function automatic logic [6:0] font(input logic [6:0] c, input int k);
        return 7'(c * 7'h0b) ^ 7'(k * 7'h25);
    endfunction

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
            errors++;
        end
    endtask

    // One host write, waits for busy to clear
    task automatic host_write(input logic [1:0] s, input logic [9:0] a, input logic [7:0] d);
        int n;
        @(posedge host_clock);
        #1;
        host_wr = 1'b1;
        req = '{sel: s, addr: a, data: d};
        @(posedge host_clock);
        #1;
        host_wr = 1'b0;
        chk("busy", 1, busy);
        for (n = 0; n < 40 && busy !== 1'b0; n++) begin
            @(posedge host_clock);
            #1;
        end
        if (n >= 40) begin
            chk("busy release", 0, busy);
            end_of_test();
        end
    endtask

    // Wait for the end of the next load
    task automatic wait_lit();
        int n;
        for (n = 0; n < 12000 && blank !== 1'b1; n++) begin
            @(posedge clock);
            #1;
        end
        for (n = n; n < 12000 && blank !== 1'b0; n++) begin
            @(posedge clock);
            #1;
        end
        if (n >= 12000) begin
            $display("MISMATCH load wait expected lit seen timeout");
            errors++;
            end_of_test();
        end
    endtask

    function automatic int cur_col();
        for (int j = 0; j < 5; j++)
            if (col[j]) return j;
        return 0;
    endfunction

    // Column select and every character slice
    task automatic check_frame(input int k);
        chk("column", 32'(1 << k), 32'(col));
        for (int c = 0; c < 32; c++)
            chk("char dots", 32'(font(code_q[c][6:0], k)), 32'(shift[223-7*c -: 7]));
    endtask

    task automatic t_reset();
        chk("blank", 1, blank);
        chk("columns", 0, col);
        chk("disp clock", 0, dclk);
        chk("busy", 0, busy);
        $display("test reset done");
    endtask

    // Per character, font for its code, then its code memory word
    task automatic t_fill();
        for (int c = 0; c < 32; c++) begin
            code_q[c] = 8'(c * 3 + 8'h21);
            for (int k = 0; k < 5; k++)
                host_write(2'h1, 10'(k * 128 + code_q[c][6:0]), {1'b0, font(code_q[c][6:0], k)});
            host_write(2'h0, 10'(c), code_q[c]);
        end
        $display("test fill done");
    endtask

    // Six loads in a row, columns wrap
    task automatic t_scan();
        int k0;
        wait_lit();
        k0 = cur_col();
        for (int i = 0; i < 6; i++) begin
            wait_lit();
            check_frame((k0 + 1 + i) % 5);
        end
        col_k = (k0 + 6) % 5;
        $display("test scan done");
    endtask

    // Host write while the scan runs
    task automatic t_host();
        code_q[5] = code_q[0];
        host_write(2'h0, 10'h005, code_q[5]);
        wait_lit();
        wait_lit();
        check_frame((col_k + 2) % 5);
        col_k = (col_k + 2) % 5;
        $display("test host done");
    endtask

    // Dot-image bytes take the bit-serial path, coded scan unchanged
    task automatic t_dots();
        for (int k = 0; k < 5; k++)
            host_write(2'h2, {3'(k), 7'h03}, {1'b0, font(7'h03, k)});
        wait_lit();
        wait_lit();
        check_frame((col_k + 2) % 5);
        col_k = (col_k + 2) % 5;
        $display("test dots done");
    endtask

    // Reset while lit, restart at column zero
    task automatic t_reset_mid();
        wait_lit();
        repeat (40) @(posedge clock);
        #1;
        reset = 1'b1;
        repeat (20) @(posedge clock);
        chk("blank", 1, blank);
        chk("columns", 0, col);
        #1;
        reset = 1'b0;
        wait_lit();
        check_frame(0);
        $display("test reset mid done");
    endtask

    initial begin
        repeat (16) @(posedge clock);
        #1;
        reset = 1'b0;
        t_reset();
        t_fill();
        t_scan();
        t_host();
        t_dots();
        t_reset_mid();
        end_of_test();
    end
endmodule

bind lmsr_refresh lmsr_refresh_monitor #(.CHARS(CHARS), .SCAN_W(SCAN_W)) u_lmsr_refresh_monitor (
    .i_clock(i_clock), .i_reset(i_reset), .i_host_clock(i_host_clock), .i_host_wr(i_host_wr),
    .o_host_busy(o_host_busy), .o_disp_data(o_disp_data), .o_disp_clock(o_disp_clock),
    .o_disp_blank(o_disp_blank), .o_col_on(o_col_on));
